//--- hw/twc_pkg.sv
// Constants and types shared by the two-wire client block
package twc_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [5:0] IDX_HOST_CTRL_A = 6'h03;
  localparam logic [5:0] IDX_CTRL_A = 6'h09;
  localparam logic [5:0] IDX_CTRL_B = 6'h0a;
  localparam logic [5:0] IDX_STATUS = 6'h0b;
  localparam logic [5:0] IDX_MATCH = 6'h0c;
  localparam logic [5:0] IDX_DATA = 6'h0d;
  // Reset value and writable bits
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CTRL_A_MASK = 8'he7;
  // Field positions
  localparam int CA_STOP_IRQ_EN = 5;
  localparam int CA_PMEN = 2;
  localparam int CA_SMART_MODE_EN = 1;
  localparam int CA_EN = 0;
  localparam int CB_ACK = 2;
  localparam int ST_COLLISION_FLAG = 3;
  localparam int ST_BUS_ERROR_FLAG = 2;
  localparam int HA_EN = 0;
  // Client command codes
  localparam logic [1:0] CMD_NO_ACTION = 2'h0;
  localparam logic [1:0] CMD_RESERVED = 2'h1;
  localparam logic [1:0] CMD_COMPLETE = 2'h2;
  localparam logic [1:0] CMD_RESPONSE = 2'h3;
  // Where the link goes after an acknowledge bit
  localparam logic [1:0] THEN_IDLE = 2'h0;
  localparam logic [1:0] THEN_RX = 2'h1;
  localparam logic [1:0] THEN_DIF = 2'h2;
  // Misc
  localparam logic [6:0] GENERAL_CALL = 7'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [23:0] DAT_PAD = 24'h000000;
  // Link states, Gray coded in declaration order; the returns from RX and TACK to HOLD flip two bits
  typedef enum logic [2:0] {
    TWC_IDLE = 3'h0, TWC_ADDR = 3'h1, TWC_HOLD = 3'h3, TWC_ACK = 3'h2,
    TWC_RX = 3'h6, TWC_TX = 3'h7, TWC_TACK = 3'h5
  } twc_state_t;
  // Client status register layout
  typedef struct packed {
    logic data_irq_flag; logic addr_stop_irq_flag; logic hold; logic received_ack_status;
    logic collision_flag; logic bus_error_flag; logic dir; logic ap;
  } twc_status_t;
  // One Wishbone request bundled
  typedef struct packed {
    logic [7:0] adr; logic we; logic [3:0] sel; logic [31:0] dat;
  } twc_wb_req_t;
endpackage

//--- hw/twc_client.sv
// Two-wire client: command, status and address registers with its link engine
//
// Notes on behaviour
// - Ack select 0 sends ACK, 1 sends NACK
// - Smart mode: data read in host write performs acknowledge action
// - Data write never performs the acknowledge action
// - Command field is a strobe, reads zero
// - Code 0 does nothing; code 1 reserved
// - Code 2 ends transaction, waits for start
// - Code 3, host write: ack, receive next
// - Code 3 after address, read: ack, data flag
// - Code 3 after data, read: send byte, ack
// - Ack select updates before same-write command
// - Data flag set on byte end; an ack collision sets the address flag instead
// - Data access or command clears both flags
// - Address flag set on match or stop
// - Hold state holds clock low; a response or complete command, or a smart read, releases it
// - Received-ack bit records host's last ack
// - Collision on lost high bit or on NACK after address
// - Collision clears on write one or start
// - Bus error on bad start/stop; write-one clears
// - Bus error needs host enable set
// - Direction holds last address read/write bit
// - Cause bit: 0 stop, 1 address
// - Match address upper bits; bit0 general call
// - Stop sets address flag only if enabled
`timescale 1ns/1ps
module twc_client (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Register index hit for a request
  function automatic logic hit(input twc_pkg::twc_wb_req_t r, input logic [5:0] idx);
    return r.adr[7:2] == idx;
  endfunction

  // Address match against match register
  function automatic logic addr_match(input logic [7:0] a, input logic [7:0] m, input logic perm);
    logic gc;
    gc = m[0] && (a[7:1] == twc_pkg::GENERAL_CALL);
    return perm || (a[7:1] == m[7:1]) || gc;
  endfunction

  // ----------------------------------------------------------------
  // Bus request decode
  // ----------------------------------------------------------------
  twc_pkg::twc_wb_req_t req; // Bundled request
  logic ack; // Registered ack
  logic [7:0] rdata; // Registered read byte
  logic done; // Cycle where the access takes effect
  logic wr; // Effective write on low lane
  logic rd; // Effective read
  logic cmd_wr; // Write to control B
  logic data_wr; // Write to data register
  logic data_rd; // Read of data register
  logic stat_wr; // Write to status register
  logic flag_clr; // Clears both interrupt flags

  assign req = '{adr: adr_i, we: we_i, sel: sel_i, dat: dat_i};
  assign done = cyc_i && stb_i && ack;
  assign wr = done && req.we && req.sel[0];
  assign rd = done && !req.we;
  assign cmd_wr = wr && hit(req, twc_pkg::IDX_CTRL_B);
  assign data_wr = wr && hit(req, twc_pkg::IDX_DATA);
  assign data_rd = rd && hit(req, twc_pkg::IDX_DATA);
  assign stat_wr = wr && hit(req, twc_pkg::IDX_STATUS);
  assign flag_clr = data_wr || data_rd || cmd_wr;
  assign ack_o = ack;
  assign dat_o = {twc_pkg::DAT_PAD, rdata};

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_a; // Client control A
  logic host_en; // Host enable bit
  logic ack_sel; // Acknowledge action select
  logic [7:0] match; // Client match address
  logic next_ack;
  logic [7:0] next_rdata;
  logic [7:0] next_ctrl_a;
  logic next_host_en;
  logic next_ack_sel;
  logic [7:0] next_match;
  twc_pkg::twc_status_t status; // Client status flags
  logic [7:0] shift; // Client data / shift register

  // Next values of the bus-facing registers
  always_comb begin
    next_ack = cyc_i && stb_i && !ack;
    next_ctrl_a = ctrl_a;
    next_host_en = host_en;
    next_ack_sel = ack_sel;
    next_match = match;
    // Read data sampled in the cycle the ack rises
    next_rdata = twc_pkg::REG_RESET;
    if (req.adr[7:2] == twc_pkg::IDX_CTRL_A) begin
      next_rdata = ctrl_a;
    end else if (req.adr[7:2] == twc_pkg::IDX_HOST_CTRL_A) begin
      next_rdata[twc_pkg::HA_EN] = host_en;
    end else if (req.adr[7:2] == twc_pkg::IDX_CTRL_B) begin
      next_rdata[twc_pkg::CB_ACK] = ack_sel; // command bits read zero
    end else if (req.adr[7:2] == twc_pkg::IDX_STATUS) begin
      next_rdata = status;
    end else if (req.adr[7:2] == twc_pkg::IDX_MATCH) begin
      next_rdata = match;
    end else if (req.adr[7:2] == twc_pkg::IDX_DATA) begin
      next_rdata = shift;
    end
    // Writes land on the ack edge
    if (wr && hit(req, twc_pkg::IDX_CTRL_A)) begin
      next_ctrl_a = req.dat[7:0] & twc_pkg::CTRL_A_MASK;
    end
    if (wr && hit(req, twc_pkg::IDX_HOST_CTRL_A)) begin
      next_host_en = req.dat[twc_pkg::HA_EN];
    end
    if (cmd_wr) begin
      next_ack_sel = req.dat[twc_pkg::CB_ACK];
    end
    if (wr && hit(req, twc_pkg::IDX_MATCH)) begin
      next_match = req.dat[7:0];
    end
  end

  // Register the bus-facing state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdata <= twc_pkg::REG_RESET;
      ctrl_a <= twc_pkg::REG_RESET;
      host_en <= 1'b0;
      ack_sel <= 1'b0;
      match <= twc_pkg::REG_RESET;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      ctrl_a <= next_ctrl_a;
      host_en <= next_host_en;
      ack_sel <= next_ack_sel;
      match <= next_match;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and bus conditions
  // ----------------------------------------------------------------
  logic scl_meta, scl_sync, scl_prev; // Clock line stages
  logic sda_meta, sda_sync, sda_prev; // Data line stages

  // Two flops per pin, then one more for edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_meta <= scl_i;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_i;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_sync && !scl_prev;
  assign scl_fall = !scl_sync && scl_prev;
  // Data edges while the clock stays high
  assign start_det = scl_sync && scl_prev && sda_prev && !sda_sync;
  assign stop_det = scl_sync && scl_prev && !sda_prev && sda_sync;

  // ----------------------------------------------------------------
  // Link engine and status flags
  // ----------------------------------------------------------------
  twc_pkg::twc_state_t state; // Link state
  logic [3:0] cnt; // Bits of the current byte
  logic hold_data; // Hold follows data, not address
  logic [1:0] then_go; // Destination after ack bit
  logic sda_oe; // Pulling the data line low
  logic in_addr; // Current ack answers an address
  twc_pkg::twc_state_t next_state;
  logic [3:0] next_cnt;
  logic next_hold_data;
  logic [1:0] next_then;
  logic next_sda_oe;
  logic next_in_addr;
  twc_pkg::twc_status_t next_status;
  logic [7:0] next_shift;
  logic enable, smart, go_resp, go_comp, eff_ack, mid_byte;

  assign enable = ctrl_a[twc_pkg::CA_EN];
  assign smart = ctrl_a[twc_pkg::CA_SMART_MODE_EN];
  // Code 0 and reserved code 1 start nothing
  assign go_resp = (cmd_wr && req.dat[1:0] == twc_pkg::CMD_RESPONSE)
                   || (data_rd && smart && !status.dir);
  assign go_comp = cmd_wr && req.dat[1:0] == twc_pkg::CMD_COMPLETE;
  // Same-write ack select takes effect first
  assign eff_ack = cmd_wr ? req.dat[twc_pkg::CB_ACK] : ack_sel;
  // The clock rise inside a legal stop or repeated start counts one bit, so a torn byte has two or more
  assign mid_byte = (cnt > 4'h1) && (state == twc_pkg::TWC_ADDR
                    || state == twc_pkg::TWC_RX || state == twc_pkg::TWC_TX);

  // Next state of the link and flags
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_hold_data = hold_data;
    next_then = then_go;
    next_sda_oe = sda_oe;
    next_in_addr = in_addr;
    next_status = status;
    next_shift = shift;
    // Software clears come first so hardware sets win
    if (flag_clr) begin
      next_status.data_irq_flag = 1'b0;
      next_status.addr_stop_irq_flag = 1'b0;
    end
    if (stat_wr && req.dat[twc_pkg::ST_COLLISION_FLAG]) begin
      next_status.collision_flag = 1'b0;
    end
    if (stat_wr && req.dat[twc_pkg::ST_BUS_ERROR_FLAG]) begin
      next_status.bus_error_flag = 1'b0;
    end
    // A data write loads the shifter but starts nothing
    if (data_wr) begin
      next_shift = req.dat[7:0];
    end
    if (!enable) begin
      // Disabled client lets go of the bus
      next_state = twc_pkg::TWC_IDLE;
      next_sda_oe = 1'b0;
    end else if (start_det) begin
      // Start or repeated start opens an address byte
      if (host_en && mid_byte) begin
        next_status.bus_error_flag = 1'b1;
      end
      next_status.collision_flag = 1'b0;
      next_state = twc_pkg::TWC_ADDR;
      next_cnt = 4'h0;
      next_sda_oe = 1'b0;
    end else if (stop_det) begin
      // Stop ends any transfer
      // Stop inside a byte, or before the address byte was taken
      if (host_en && (mid_byte || state == twc_pkg::TWC_ADDR)) begin
        next_status.bus_error_flag = 1'b1;
      end
      if (ctrl_a[twc_pkg::CA_STOP_IRQ_EN]) begin
        next_status.addr_stop_irq_flag = 1'b1;
        next_status.ap = 1'b0;
      end
      next_state = twc_pkg::TWC_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      unique case (state)
        twc_pkg::TWC_IDLE: begin
          // Waiting for a start
          next_sda_oe = 1'b0;
        end
        twc_pkg::TWC_ADDR: begin
          // Collect address byte, decide at the eighth fall
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_sync};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == twc_pkg::BYTE_BITS) begin
            if (addr_match(shift, match, ctrl_a[twc_pkg::CA_PMEN])) begin
              next_status.addr_stop_irq_flag = 1'b1;
              next_status.ap = 1'b1;
              next_status.dir = shift[0];
              next_hold_data = 1'b0;
              next_state = twc_pkg::TWC_HOLD;
            end else begin
              next_state = twc_pkg::TWC_IDLE;
            end
          end
        end
        twc_pkg::TWC_HOLD: begin
          // Clock held low until software answers
          next_cnt = 4'h0;
          next_in_addr = !hold_data;
          if (go_resp) begin
            if (status.dir && hold_data) begin
              // Read after data: send next byte
              next_state = twc_pkg::TWC_TX;
              next_sda_oe = !shift[7];
            end else begin
              // Ack action, then receive or data flag
              next_state = twc_pkg::TWC_ACK;
              next_sda_oe = !eff_ack;
              next_then = status.dir ? twc_pkg::THEN_DIF : twc_pkg::THEN_RX;
            end
          end else if (go_comp) begin
            // Complete: ack only in host write
            if (status.dir) begin
              next_state = twc_pkg::TWC_IDLE;
            end else begin
              next_state = twc_pkg::TWC_ACK;
              next_sda_oe = !eff_ack;
              next_then = twc_pkg::THEN_IDLE;
            end
          end
        end
        twc_pkg::TWC_ACK: begin
          // Drive the acknowledge bit for one clock pulse
          if (scl_rise && !sda_oe && !sda_sync && in_addr) begin
            next_status.collision_flag = 1'b1;
            next_status.addr_stop_irq_flag = 1'b1;
          end else if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_cnt = 4'h0;
            if (!sda_oe || then_go == twc_pkg::THEN_IDLE) begin
              next_state = twc_pkg::TWC_IDLE;
            end else if (then_go == twc_pkg::THEN_RX) begin
              next_state = twc_pkg::TWC_RX;
            end else begin
              next_status.data_irq_flag = 1'b1;
              next_hold_data = 1'b1;
              next_state = twc_pkg::TWC_HOLD;
            end
          end
        end
        twc_pkg::TWC_RX: begin
          // Receive a byte from the host
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_sync};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == twc_pkg::BYTE_BITS) begin
            next_status.data_irq_flag = 1'b1;
            next_hold_data = 1'b1;
            next_state = twc_pkg::TWC_HOLD;
          end
        end
        twc_pkg::TWC_TX: begin
          // Send a byte, most significant bit first
          if (scl_rise) begin
            if (!sda_oe && !sda_sync) begin
              next_status.collision_flag = 1'b1;
            end
            next_shift = {shift[6:0], sda_sync};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall) begin
            if (cnt == twc_pkg::BYTE_BITS) begin
              next_sda_oe = 1'b0;
              next_state = twc_pkg::TWC_TACK;
            end else begin
              // After a collision stop driving the line
              next_sda_oe = !shift[7] && !status.collision_flag;
            end
          end
        end
        twc_pkg::TWC_TACK: begin
          // Sample the host acknowledge
          if (scl_rise) begin
            next_status.received_ack_status = sda_sync;
          end else if (scl_fall) begin
            next_status.data_irq_flag = 1'b1;
            next_hold_data = 1'b1;
            next_state = twc_pkg::TWC_HOLD;
          end
        end
        default: begin
          // Unused code recovers to idle
          next_state = twc_pkg::TWC_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
    // Clock hold status follows the hold state
    next_status.hold = next_state == twc_pkg::TWC_HOLD;
  end

  // Register the link state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= twc_pkg::TWC_IDLE;
      cnt <= 4'h0;
      hold_data <= 1'b0;
      then_go <= twc_pkg::THEN_IDLE;
      sda_oe <= 1'b0;
      in_addr <= 1'b0;
      status <= twc_pkg::REG_RESET;
      shift <= twc_pkg::REG_RESET;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      hold_data <= next_hold_data;
      then_go <= next_then;
      sda_oe <= next_sda_oe;
      in_addr <= next_in_addr;
      status <= next_status;
      shift <= next_shift;
    end
  end

  // Open-drain pins only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = status.hold;
  assign sda_oe_o = sda_oe;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_addr_done;
    state == twc_pkg::TWC_ADDR ##1 state == twc_pkg::TWC_HOLD;
  endsequence
  sequence s_ack_cmd;
    state == twc_pkg::TWC_HOLD && !status.dir && cmd_wr
    && req.dat[1:0] == twc_pkg::CMD_RESPONSE && !req.dat[twc_pkg::CB_ACK];
  endsequence

  AST_CMD_READS_ZERO: assert property (
    ack && !we_i && adr_i[7:2] == twc_pkg::IDX_CTRL_B |-> dat_o[1:0] == 2'h0)
    else $error("command field read back non-zero");
  AST_ADDR_FLAGS: assert property (
    s_addr_done |-> status.addr_stop_irq_flag && status.ap && scl_oe_o)
    else $error("address match did not raise flag and hold");
  AST_ACK_DRIVEN: assert property (
    s_ack_cmd |=> state == twc_pkg::TWC_ACK && sda_oe_o)
    else $error("ACK not driven after response command");
  AST_DATA_WRITE_KEEPS: assert property (
    state == twc_pkg::TWC_HOLD && data_wr && !cmd_wr && !start_det && !stop_det
    |=> state == twc_pkg::TWC_HOLD)
    else $error("data write left the hold");
  AST_SMART_READ: assert property (
    state == twc_pkg::TWC_HOLD && data_rd && smart && !status.dir && enable
    && !start_det && !stop_det |=> state == twc_pkg::TWC_ACK)
    else $error("smart read did not trigger ack");
  AST_NOP_CMD: assert property (
    state == twc_pkg::TWC_HOLD && cmd_wr && req.dat[1] == 1'b0 && enable
    && !start_det && !stop_det |=> state == twc_pkg::TWC_HOLD)
    else $error("no-action command changed state");
  AST_FLAG_CLEAR: assert property (
    flag_clr && state == twc_pkg::TWC_HOLD && !start_det && !stop_det
    |=> !status.data_irq_flag && !status.addr_stop_irq_flag)
    else $error("access did not clear flags");
  AST_START_COLLISION_FLAG: assert property (
    start_det && enable |=> !status.collision_flag ##1 state == twc_pkg::TWC_ADDR)
    else $error("start did not clear collision");
  AST_STOP_CAUSE: assert property (
    stop_det && enable && ctrl_a[twc_pkg::CA_STOP_IRQ_EN] |=> status.addr_stop_irq_flag && !status.ap)
    else $error("stop did not set flag with cause zero");
  AST_BUS_ERROR_FLAG_HOST: assert property (
    !host_en && !(stat_wr && req.dat[twc_pkg::ST_BUS_ERROR_FLAG]) |=> !$rose(status.bus_error_flag))
    else $error("bus error raised with host disabled");
  AST_HOLD_RELEASE: assert property (
    $fell(status.hold) |-> !scl_oe_o && $past(state) == twc_pkg::TWC_HOLD)
    else $error("clock hold released wrongly");

endmodule

//--- testbench/twc_host_model.sv
// Host controller model driving the two-wire bus
`timescale 1ns/1ps
module twc_host_model (
  input wire logic clk_i,
  input wire logic scl_oe_i,
  input wire logic sda_oe_i,
  output logic scl_o,
  output logic sda_o
);
  // ----------------------------------------
  // Wires
  // ----------------------------------------
  logic scl_low = 1'b0; // Host pulls clock low
  logic sda_low = 1'b0; // Host pulls data low
  // Pulled-up lines, low while either party pulls
  assign scl_o = !(scl_low || scl_oe_i);
  assign sda_o = !(sda_low || sda_oe_i);
  // 80 ns; three of these plus one clock make the 260 ns bus clock period
  task automatic half();
    repeat (4) @(posedge clk_i);
  endtask
  // One bit: set data while low, sample while high, wait out clock hold
  task automatic bitx(input logic b, output logic r);
    sda_low <= !b;
    half();
    scl_low <= 1'b0;
    // Wait out a clock hold; the bench timeout ends a stuck wait
    while (!scl_o) begin
      @(posedge clk_i);
    end
    half();
    r = sda_o;
    scl_low <= 1'b1;
    half();
  endtask
  // Eight bits, most significant first
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
  endtask
  // Data falls while clock high
  task automatic start();
    sda_low <= 1'b1;
    half();
    scl_low <= 1'b1;
    half();
  endtask
  // Data rises while clock high
  task automatic stop();
    sda_low <= 1'b1;
    half();
    scl_low <= 1'b0;
    half();
    sda_low <= 1'b0;
    half();
  endtask
endmodule

//--- testbench/twc_client_tb.sv
// Self-checking bench for the two-wire client
`timescale 1ns/1ps
module twc_client_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h00000000;
  logic [31:0] dat_o;
  logic ack, scl, sda, scl_oe, sda_oe, r;
  logic [7:0] q, b;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  twc_client twc_client_i (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .scl_i(scl), .sda_i(sda), .scl_o(),
    .scl_oe_o(scl_oe), .sda_o(), .sda_oe_o(sda_oe));
  twc_host_model twc_host_model_i (.clk_i(clk), .scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .scl_o(scl),
    .sda_o(sda));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test();
    if (err_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %0t saw %h want %h", $time, s, e);
    end
  endtask
  // One classic Wishbone access, read data left in q
  task automatic wb(input logic w, input logic [5:0] ix, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'h0};
    dat <= {24'h000000, d};
    sel <= 4'h1;
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  // Masked register read compare
  task automatic rc(input logic [5:0] ix, input logic [7:0] m, input logic [7:0] e);
    wb(1'b0, ix, 8'h00);
    chk(q & m, e);
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc(twc_pkg::IDX_MATCH, 8'hff, 8'h00);
    wb(1'b1, twc_pkg::IDX_MATCH, 8'h54);
    rc(twc_pkg::IDX_MATCH, 8'hff, 8'h54);
    wb(1'b1, twc_pkg::IDX_HOST_CTRL_A, 8'h01);
    wb(1'b1, twc_pkg::IDX_CTRL_A, 8'h21);
    // Host write of one byte, closed with a NACK
    twc_host_model_i.start();
    twc_host_model_i.xbyte(8'h54, b);
    rc(twc_pkg::IDX_STATUS, 8'he7, 8'h61);
    wb(1'b1, twc_pkg::IDX_CTRL_B, 8'h03);
    twc_host_model_i.bitx(1'b1, r);
    chk({7'h00, r}, 8'h00);
    twc_host_model_i.xbyte(8'ha5, b);
    rc(twc_pkg::IDX_STATUS, 8'he6, 8'ha0);
    rc(twc_pkg::IDX_DATA, 8'hff, 8'ha5);
    wb(1'b1, twc_pkg::IDX_CTRL_B, 8'h06);
    twc_host_model_i.bitx(1'b1, r);
    chk({7'h00, r}, 8'h01);
    rc(twc_pkg::IDX_CTRL_B, 8'hff, 8'h04);
    rc(twc_pkg::IDX_STATUS, 8'h20, 8'h00);
    twc_host_model_i.stop();
    rc(twc_pkg::IDX_STATUS, 8'h41, 8'h40);
    wb(1'b1, twc_pkg::IDX_CTRL_B, 8'h00);
    rc(twc_pkg::IDX_STATUS, 8'h60, 8'h00);
    // Host read of one byte, host answers NACK
    twc_host_model_i.start();
    twc_host_model_i.xbyte(8'h55, b);
    rc(twc_pkg::IDX_STATUS, 8'he6, 8'h62);
    wb(1'b1, twc_pkg::IDX_CTRL_B, 8'h03);
    twc_host_model_i.bitx(1'b1, r);
    chk({7'h00, r}, 8'h00);
    rc(twc_pkg::IDX_STATUS, 8'ha0, 8'ha0);
    wb(1'b1, twc_pkg::IDX_DATA, 8'h3c);
    rc(twc_pkg::IDX_STATUS, 8'ha0, 8'h20);
    wb(1'b1, twc_pkg::IDX_CTRL_B, 8'h03);
    twc_host_model_i.xbyte(8'hff, b);
    chk(b, 8'h3c);
    twc_host_model_i.bitx(1'b1, r);
    rc(twc_pkg::IDX_STATUS, 8'h90, 8'h90);
    wb(1'b1, twc_pkg::IDX_CTRL_B, 8'h02);
    twc_host_model_i.stop();
    // Start directly followed by stop
    twc_host_model_i.start();
    twc_host_model_i.stop();
    rc(twc_pkg::IDX_STATUS, 8'h04, 8'h04);
    wb(1'b1, twc_pkg::IDX_STATUS, 8'h04);
    rc(twc_pkg::IDX_STATUS, 8'h04, 8'h00);
    // Smart mode, general call, stop flag disabled
    wb(1'b1, twc_pkg::IDX_CTRL_A, 8'h03);
    wb(1'b1, twc_pkg::IDX_MATCH, 8'h55);
    twc_host_model_i.start();
    twc_host_model_i.xbyte(8'h00, b);
    rc(twc_pkg::IDX_STATUS, 8'h63, 8'h61);
    wb(1'b1, twc_pkg::IDX_CTRL_B, 8'h00);
    rc(twc_pkg::IDX_STATUS, 8'h60, 8'h20);
    rc(twc_pkg::IDX_DATA, 8'hff, 8'h00);
    twc_host_model_i.bitx(1'b1, r);
    chk({7'h00, r}, 8'h00);
    twc_host_model_i.xbyte(8'h81, b);
    rc(twc_pkg::IDX_DATA, 8'hff, 8'h81);
    twc_host_model_i.bitx(1'b1, r);
    chk({7'h00, r}, 8'h00);
    twc_host_model_i.stop();
    rc(twc_pkg::IDX_STATUS, 8'h44, 8'h00);
    // Host side disabled: start then stop raises no bus error
    wb(1'b1, twc_pkg::IDX_HOST_CTRL_A, 8'h00);
    twc_host_model_i.start();
    twc_host_model_i.stop();
    rc(twc_pkg::IDX_STATUS, 8'h04, 8'h00);
    rc(6'h3f, 8'hff, 8'h00);
    stop_test();
  end
endmodule
